// ==== hw/rtcb_map.svh ====
// Numeric constants of the calendar clock: pin slots, limits, resets.
// Included by the keeper and clock design files; holds definitions only.
`ifndef RTCB_MAP_SVH
`define RTCB_MAP_SVH
// Slots of the synchronised pin vector.
`define RTCB_P_XT 0
`define RTCB_P_OSC 1
`define RTCB_P_RC 2
`define RTCB_P_HSE 3
`define RTCB_P_REF 4
`define RTCB_P_TS 5
`define RTCB_P_BAT 6
`define RTCB_P_SHD 7
`define RTCB_P_TAMP 8
// Event flag positions.
`define RTCB_F_ALARM 0
`define RTCB_F_WUT 2
`define RTCB_F_TS 3
`define RTCB_F_TAMP 4
// Prescaler reset values and fixed dividers.
`define RTCB_PREDIV_A_RST 7'h7f
`define RTCB_PREDIV_S_RST 16'h00ff
`define RTCB_HSE_LAST 5'h1f
`define RTCB_CAL_WIN_W 20
`define RTCB_REF50_LAST 6'h31
`define RTCB_REF60_LAST 6'h3b
// BCD calendar limits.
`define RTCB_SEC_LAST 7'h59
`define RTCB_MIN_LAST 7'h59
`define RTCB_H24_LAST 6'h23
`define RTCB_H12_LAST 6'h12
`define RTCB_H12_FLIP 6'h11
`define RTCB_H12_FIRST 6'h01
`define RTCB_WDAY_LAST 3'h7
`define RTCB_MON_LAST 5'h12
`define RTCB_YEAR_LAST 8'h99
`define RTCB_FEB 5'h02
`define RTCB_D28 6'h28
`define RTCB_D29 6'h29
`define RTCB_D30 6'h30
`define RTCB_D31 6'h31
// Calendar reset point.
`define RTCB_RST_WDAY 3'h1
`define RTCB_RST_DATE 6'h01
`define RTCB_RST_MON 5'h01
`endif

// ==== hw/rtcb_pkg.sv ====
// Types shared by the calendar clock and its timekeeper.
// Assumes rtcb_map.svh for all numeric constants.
package rtcb_pkg;
  // One calendar reading, every field in BCD.
  typedef struct packed {
    logic pm;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
    logic [2:0] wday;
    logic [4:0] month;
    logic [5:0] date;
    logic [7:0] year;
  } rtcb_cal_s;
  // Counting clock source.
  typedef enum logic [1:0] {
    SRC_XTAL,
    SRC_OSC,
    SRC_RC,
    SRC_HSE
  } rtcb_src_e;
  // Wakeup timer resolution.
  typedef enum logic [2:0] {
    WRES_DIV16,
    WRES_DIV8,
    WRES_DIV4,
    WRES_DIV2,
    WRES_1HZ,
    WRES_1HZ_EXT
  } rtcb_wres_e;
endpackage : rtcb_pkg

// ==== hw/rtcb_cal_if.sv ====
// Link between the clock controller and the calendar timekeeper.
// Assumes both ends share one clock.
interface rtcb_cal_if;
  logic sec_tick;
  logic load;
  logic fmt12;
  rtcb_pkg::rtcb_cal_s load_val;
  rtcb_pkg::rtcb_cal_s cal;
  modport keeper (input sec_tick, load, fmt12, load_val, output cal);
  modport ctrl (output sec_tick, load, fmt12, load_val, input cal);
endinterface : rtcb_cal_if

// ==== hw/rtcb_keeper.sv ====
// BCD calendar timekeeper advanced by one-second ticks.
// Assumes rtcb_map.svh and a controller driving the ctrl modport.
`include "rtcb_map.svh"
module rtcb_keeper (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  rtcb_cal_if.keeper c
);
  rtcb_pkg::rtcb_cal_s cal_ff;
  rtcb_pkg::rtcb_cal_s nxt_cal;
  logic [5:0] dim;
  logic leap;
  logic day;

  // Adds one to a two-digit BCD value.
  function automatic logic [7:0] inc(input logic [7:0] v);
    inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : inc

  // Ripples a second tick through the fields and picks month length.
  always_comb begin
    leap = cal_ff.year[4] ?
      (cal_ff.year[3:0] == 4'h2 || cal_ff.year[3:0] == 4'h6) :
      (cal_ff.year[3:0] == 4'h0 || cal_ff.year[3:0] == 4'h4 ||
       cal_ff.year[3:0] == 4'h8);
    case (cal_ff.month)
      `RTCB_FEB: dim = leap ? `RTCB_D29 : `RTCB_D28;
      5'h04, 5'h06, 5'h09, 5'h11: dim = `RTCB_D30;
      default: dim = `RTCB_D31;
    endcase
    day = 1'b0;
    nxt_cal = cal_ff;
    if (c.load) begin
      nxt_cal = c.load_val;
    end else if (c.sec_tick) begin
      if (cal_ff.sec != `RTCB_SEC_LAST) begin
        nxt_cal.sec = 7'(inc({1'b0, cal_ff.sec}));
      end else begin
        nxt_cal.sec = 7'h00;
        if (cal_ff.min != `RTCB_MIN_LAST) begin
          nxt_cal.min = 7'(inc({1'b0, cal_ff.min}));
        end else begin
          nxt_cal.min = 7'h00;
          if (c.fmt12) begin
            nxt_cal.hour = (cal_ff.hour == `RTCB_H12_LAST) ?
              `RTCB_H12_FIRST : 6'(inc({2'b00, cal_ff.hour}));
            if (cal_ff.hour == `RTCB_H12_FLIP) begin
              nxt_cal.pm = ~cal_ff.pm;
              day = cal_ff.pm;
            end
          end else if (cal_ff.hour == `RTCB_H24_LAST) begin
            nxt_cal.hour = 6'h00;
            day = 1'b1;
          end else begin
            nxt_cal.hour = 6'(inc({2'b00, cal_ff.hour}));
          end
        end
      end
    end
    if (day) begin
      nxt_cal.wday = (cal_ff.wday == `RTCB_WDAY_LAST) ?
        `RTCB_RST_WDAY : cal_ff.wday + 3'h1;
      if (cal_ff.date != dim) begin
        nxt_cal.date = 6'(inc({2'b00, cal_ff.date}));
      end else begin
        nxt_cal.date = `RTCB_RST_DATE;
        if (cal_ff.month != `RTCB_MON_LAST) begin
          nxt_cal.month = 5'(inc({3'b000, cal_ff.month}));
        end else begin
          nxt_cal.month = `RTCB_RST_MON;
          nxt_cal.year = (cal_ff.year == `RTCB_YEAR_LAST) ?
            8'h00 : inc(cal_ff.year);
        end
      end
    end
  end

  // Registers the calendar.
  always_ff @(posedge clock) begin
    if (reset) begin
      cal_ff <= '0;
      cal_ff.wday <= `RTCB_RST_WDAY;
      cal_ff.date <= `RTCB_RST_DATE;
      cal_ff.month <= `RTCB_RST_MON;
    end else if (clk_en) begin
      cal_ff <= nxt_cal;
    end
  end

  assign c.cal = cal_ff;

  // Seconds wrap into the minutes.
  property p_sec_wrap;
    @(posedge clock) disable iff (reset)
      clk_en && c.sec_tick && !c.load && cal_ff.sec == `RTCB_SEC_LAST
      |=> cal_ff.sec == 7'h00 && $changed(cal_ff.min);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("Seconds did not wrap into minutes.");

  // The last day of a month returns the date to the first.
  property p_month_end;
    @(posedge clock) disable iff (reset)
      clk_en && day && cal_ff.date == dim
      |=> cal_ff.date == `RTCB_RST_DATE;
  endproperty
  a_month_end: assert property (p_month_end)
    else $error("Date did not roll over at month end.");
endmodule : rtcb_keeper

// ==== hw/rtcb_rtc.sv ====
// Battery-backed calendar clock with alarms, wakeup, tamper, backup.
// Assumes rtcb_map.svh, rtcb_pkg and a single system clock.
`include "rtcb_map.svh"
module rtcb_rtc #(
  parameter int N_TAMP = 3,
  parameter int N_BKP = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic low_speed_external_osc_xtal,
  input wire logic low_speed_external_osc_ext,
  input wire logic low_speed_internal_rc,
  input wire logic high_speed_external_osc,
  input wire rtcb_pkg::rtcb_src_e src_sel,
  input wire logic on_battery,
  input wire logic shutdown_mode,
  input wire logic [6:0] prediv_a,
  input wire logic [14:0] prediv_s,
  input wire logic [8:0] cal_minus,
  input wire logic shift_req,
  input wire logic shift_add1s,
  input wire logic [14:0] shift_amt,
  input wire logic ref_en,
  input wire logic ref_60,
  input wire logic ref_pin,
  input wire logic fmt12,
  input wire logic cal_load,
  input wire rtcb_pkg::rtcb_cal_s cal_wval,
  output logic [15:0] subsec,
  output rtcb_pkg::rtcb_cal_s cal_now,
  input wire logic [1:0] alarm_en,
  input wire rtcb_pkg::rtcb_cal_s [1:0] alarm_val,
  input wire logic [1:0][3:0] alarm_mask,
  input wire logic wut_en,
  input wire rtcb_pkg::rtcb_wres_e wut_res,
  input wire logic [15:0] wut_reload,
  input wire logic [N_TAMP-1:0] tamp_pin,
  input wire logic [N_TAMP-1:0] tamp_en,
  input wire logic [1:0] tamp_flt,
  input wire logic tamp_ts,
  input wire logic ts_pin,
  input wire logic ts_en,
  output rtcb_pkg::rtcb_cal_s ts_cal,
  output logic [15:0] ts_subsec,
  input wire logic bkp_we,
  input wire logic [$clog2(N_BKP)-1:0] bkp_addr,
  input wire logic [31:0] bkp_wdata,
  output logic [31:0] bkp_rdata,
  input wire logic [N_TAMP+3:0] evt_en,
  input wire logic [N_TAMP+3:0] evt_clr,
  output logic [N_TAMP+3:0] evt_flags,
  output logic evt_wakeup
);
  localparam int PW = `RTCB_P_TAMP + N_TAMP;
  localparam int NE = N_TAMP + 4;

  // Refuses sizes that the flag and address logic cannot carry.
  if (N_TAMP < 1 || N_TAMP > 4) begin : g_bad_tamp
    $error("N_TAMP must lie between 1 and 4.");
  end
  if (N_BKP < 2 || N_BKP > 32 || (N_BKP & (N_BKP - 1)) != 0) begin : g_bad_bkp
    $error("N_BKP must be a power of two up to 32.");
  end

  rtcb_cal_if c ();
  logic [PW-1:0] pins, sync1_ff, sync2_ff, prev_ff, rise;
  logic [4:0] hse_ff, nxt_hse;
  logic [`RTCB_CAL_WIN_W-1:0] win_ff, nxt_win;
  logic [6:0] pa_ff, nxt_pa;
  logic [15:0] ss_ff, nxt_ss, ts_ss_ff, nxt_ts_ss;
  logic [5:0] ref_ff, nxt_ref;
  logic [3:0] div_ff, nxt_div, need;
  logic [16:0] wut_ff, nxt_wut;
  logic [NE-1:0] flags_ff, nxt_flags, evt_set;
  logic [1:0] al_hit;
  logic [N_TAMP-1:0] tamp_hit;
  logic [31:0] bkp_rd_ff;
  logic [31:0] bkp_mem [N_BKP];
  rtcb_pkg::rtcb_cal_s ts_cal_ff, nxt_ts_cal;
  logic sec_d_ff, irq_ff, nxt_irq;
  logic rc_off, ck_tick, cal_tick, spre, ss_sec, add_sec, ref_sec;
  logic sec_tick, wut_step, wut_hit, ts_trig;

  rtcb_keeper u_keeper (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .c(c.keeper)
  );

  // Calendar link and the register-fed outputs.
  assign c.sec_tick = sec_tick;
  assign c.load = cal_load;
  assign c.load_val = cal_wval;
  assign c.fmt12 = fmt12;
  assign cal_now = c.cal;
  assign subsec = ss_ff;
  assign ts_cal = ts_cal_ff;
  assign ts_subsec = ts_ss_ff;
  assign bkp_rdata = bkp_rd_ff;
  assign evt_flags = flags_ff;
  assign evt_wakeup = irq_ff;

  // Two-stage synchroniser on every pin; rising edges from stage two.
  assign pins = {tamp_pin, shutdown_mode, on_battery, ts_pin, ref_pin,
    high_speed_external_osc, low_speed_internal_rc,
    low_speed_external_osc_ext, low_speed_external_osc_xtal};
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else if (clk_en) begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end
  assign rise = sync2_ff & ~prev_ff;
  assign need = 4'h1 << tamp_flt;

  // Alarm comparators; a masked field always matches.
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    assign al_hit[i] = alarm_en[i] & sec_d_ff
      & (alarm_mask[i][0] | c.cal.sec == alarm_val[i].sec)
      & (alarm_mask[i][1] | c.cal.min == alarm_val[i].min)
      & (alarm_mask[i][2] | ({c.cal.pm, c.cal.hour} ==
         {alarm_val[i].pm, alarm_val[i].hour}))
      & (alarm_mask[i][3] | c.cal.date == alarm_val[i].date);
  end

  // Tamper filters: edge mode, or 2, 4 or 8 steady samples.
  for (genvar i = 0; i < N_TAMP; i++) begin : g_tamp
    logic [3:0] cnt_ff, nxt_cnt;
    logic lvl;
    always_comb begin
      lvl = sync2_ff[`RTCB_P_TAMP+i] & tamp_en[i];
      nxt_cnt = lvl ? cnt_ff : 4'h0;
      if (lvl && cnt_ff != need) begin
        nxt_cnt = cnt_ff + 4'h1;
      end
    end
    always_ff @(posedge clock) begin
      if (reset) begin
        cnt_ff <= 4'h0;
      end else if (clk_en) begin
        cnt_ff <= nxt_cnt;
      end
    end
    assign tamp_hit[i] = (tamp_flt == 2'h0) ?
      rise[`RTCB_P_TAMP+i] & tamp_en[i] : lvl & (cnt_ff == need - 4'h1);
  end

  // Counting chain, wakeup timer, timestamp and event flags.
  always_comb begin
    nxt_hse = hse_ff;
    nxt_win = win_ff;
    nxt_pa = pa_ff;
    nxt_ss = ss_ff;
    nxt_ref = ref_ff;
    nxt_div = div_ff;
    nxt_wut = wut_ff;
    nxt_ts_cal = ts_cal_ff;
    nxt_ts_ss = ts_ss_ff;
    rc_off = sync2_ff[`RTCB_P_BAT] | sync2_ff[`RTCB_P_SHD];
    case (src_sel)
      rtcb_pkg::SRC_XTAL: ck_tick = rise[`RTCB_P_XT];
      rtcb_pkg::SRC_OSC: ck_tick = rise[`RTCB_P_OSC];
      rtcb_pkg::SRC_RC: ck_tick = rise[`RTCB_P_RC] & ~rc_off;
      default: ck_tick = rise[`RTCB_P_HSE] & (hse_ff == `RTCB_HSE_LAST);
    endcase
    if (rise[`RTCB_P_HSE]) begin
      nxt_hse = hse_ff + 5'h01;
    end
    cal_tick = ck_tick & (win_ff >= `RTCB_CAL_WIN_W'(cal_minus));
    if (ck_tick) begin
      nxt_win = win_ff + `RTCB_CAL_WIN_W'(1);
      nxt_div = div_ff + 4'h1;
    end
    spre = cal_tick & (pa_ff == 7'h00);
    if (cal_tick) begin
      nxt_pa = spre ? prediv_a : pa_ff - 7'h01;
    end
    ss_sec = spre & (ss_ff == 16'h0000);
    add_sec = shift_req & shift_add1s & (shift_amt != 15'h0000);
    if (shift_req && shift_amt != 15'h0000) begin
      nxt_ss = ss_ff + {1'b0, shift_amt};
    end else if (spre) begin
      nxt_ss = ss_sec ? {1'b0, prediv_s} : ss_ff - 16'h0001;
    end
    ref_sec = 1'b0;
    if (rise[`RTCB_P_REF]) begin
      ref_sec = ref_ff == (ref_60 ? `RTCB_REF60_LAST : `RTCB_REF50_LAST);
      nxt_ref = ref_sec ? 6'h00 : ref_ff + 6'h01;
    end
    sec_tick = (ref_en ? ref_sec : ss_sec) | add_sec;
    case (wut_res)
      rtcb_pkg::WRES_DIV16: wut_step = ck_tick & (div_ff == 4'hf);
      rtcb_pkg::WRES_DIV8: wut_step = ck_tick & (&div_ff[2:0]);
      rtcb_pkg::WRES_DIV4: wut_step = ck_tick & (&div_ff[1:0]);
      rtcb_pkg::WRES_DIV2: wut_step = ck_tick & div_ff[0];
      default: wut_step = sec_d_ff;
    endcase
    wut_hit = 1'b0;
    if (!wut_en) begin
      nxt_wut = {wut_res == rtcb_pkg::WRES_1HZ_EXT, wut_reload};
    end else if (wut_step) begin
      wut_hit = wut_ff == 17'h0_0000;
      nxt_wut = wut_hit ? {wut_res == rtcb_pkg::WRES_1HZ_EXT, wut_reload}
        : wut_ff - 17'h0_0001;
    end
    ts_trig = (ts_en & rise[`RTCB_P_TS]) | (tamp_ts & (|tamp_hit))
      | rise[`RTCB_P_BAT];
    if (ts_trig) begin
      nxt_ts_cal = c.cal;
      nxt_ts_ss = ss_ff;
    end
    evt_set = {tamp_hit, ts_trig, wut_hit, al_hit};
    nxt_flags = (flags_ff & ~evt_clr) | evt_set;
    nxt_irq = |(nxt_flags & evt_en);
  end

  // Registers the counting chain and event state.
  always_ff @(posedge clock) begin
    if (reset) begin
      hse_ff <= 5'h00;
      win_ff <= '0;
      pa_ff <= `RTCB_PREDIV_A_RST;
      ss_ff <= `RTCB_PREDIV_S_RST;
      ref_ff <= 6'h00;
      div_ff <= 4'h0;
      wut_ff <= 17'h0_0000;
      ts_cal_ff <= '0;
      ts_ss_ff <= 16'h0000;
      flags_ff <= '0;
      irq_ff <= 1'b0;
      sec_d_ff <= 1'b0;
    end else if (clk_en) begin
      hse_ff <= nxt_hse;
      win_ff <= nxt_win;
      pa_ff <= nxt_pa;
      ss_ff <= nxt_ss;
      ref_ff <= nxt_ref;
      div_ff <= nxt_div;
      wut_ff <= nxt_wut;
      ts_cal_ff <= nxt_ts_cal;
      ts_ss_ff <= nxt_ts_ss;
      flags_ff <= nxt_flags;
      irq_ff <= nxt_irq;
      sec_d_ff <= sec_tick;
    end
  end

  // Backup words have no reset so their contents outlive it.
  always_ff @(posedge clock) begin
    if (clk_en && bkp_we) begin
      bkp_mem[bkp_addr] <= bkp_wdata;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      bkp_rd_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      bkp_rd_ff <= bkp_mem[bkp_addr];
    end
  end

  property p_shift;
    @(posedge clock) disable iff (reset)
      clk_en && shift_req && shift_amt != 15'h0000
      |=> ss_ff == $past(ss_ff) + {1'b0, $past(shift_amt)};
  endproperty
  a_shift: assert property (p_shift)
    else $error("Time shift not applied to subseconds.");

  property p_ref;
    @(posedge clock) disable iff (reset)
      clk_en && ref_en && sec_tick && !add_sec |-> rise[`RTCB_P_REF];
  endproperty
  a_ref: assert property (p_ref)
    else $error("Second tick without reference edge.");

  property p_cal;
    @(posedge clock) disable iff (reset)
      ck_tick && win_ff < `RTCB_CAL_WIN_W'(cal_minus) |-> !cal_tick;
  endproperty
  a_cal: assert property (p_cal)
    else $error("Calibration failed to drop a pulse.");

  property p_tamp;
    @(posedge clock) disable iff (reset)
      |tamp_hit |-> |(tamp_en & sync2_ff[PW-1:`RTCB_P_TAMP]);
  endproperty
  a_tamp: assert property (p_tamp)
    else $error("Tamper event from an idle input.");

  property p_ts;
    @(posedge clock) disable iff (reset)
      clk_en && ts_trig |=> ts_cal_ff == $past(c.cal) && flags_ff[`RTCB_F_TS];
  endproperty
  a_ts: assert property (p_ts)
    else $error("Timestamp not captured.");

  property p_wut;
    @(posedge clock) disable iff (reset)
      clk_en && wut_en && wut_step && wut_ff == 17'h0_0000
      |=> flags_ff[`RTCB_F_WUT] && wut_ff[15:0] == $past(wut_reload);
  endproperty
  a_wut: assert property (p_wut)
    else $error("Wakeup timer did not reload and flag.");

  property p_rc_stop;
    @(posedge clock) disable iff (reset)
      src_sel == rtcb_pkg::SRC_RC && rc_off |-> !ck_tick;
  endproperty
  a_rc_stop: assert property (p_rc_stop)
    else $error("RC source counted on battery or shutdown.");

  property p_flag;
    @(posedge clock) disable iff (reset)
      clk_en && |evt_set |=> (flags_ff & $past(evt_set)) == $past(evt_set)
      ##1 evt_wakeup == |(flags_ff & evt_en);
  endproperty
  a_flag: assert property (p_flag)
    else $error("Event flag lost or wakeup mismatch.");
endmodule : rtcb_rtc

// ==== verif/rtcb_tb.sv ====
// Self-checking bench for the battery-backed calendar clock block.
// Assumes the design files under hw/ and one 10 MHz system clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic src_run = 1'b0;
  logic [1:0] src_cnt = 2'h0;
  logic src_pin;
  rtcb_pkg::rtcb_src_e src_sel = rtcb_pkg::SRC_XTAL;
  logic on_battery = 1'b0, shutdown_mode = 1'b0, shift_req = 1'b0;
  logic shift_add1s = 1'b0, ref_en = 1'b0, ref_60 = 1'b0;
  logic ref_pin = 1'b0, fmt12 = 1'b0, cal_load = 1'b0, wut_en = 1'b0;
  logic tamp_ts = 1'b0, ts_pin = 1'b0, ts_en = 1'b0, bkp_we = 1'b0;
  logic [6:0] prediv_a = 7'h00;
  logic [14:0] prediv_s = 15'h0001;
  logic [8:0] cal_minus = 9'h000;
  logic [14:0] shift_amt = 15'h0000;
  rtcb_pkg::rtcb_cal_s cal_wval = '0;
  rtcb_pkg::rtcb_cal_s v;
  logic [1:0] alarm_en = 2'h0;
  rtcb_pkg::rtcb_cal_s [1:0] alarm_val = '0;
  logic [1:0][3:0] alarm_mask = '0;
  rtcb_pkg::rtcb_wres_e wut_res = rtcb_pkg::WRES_1HZ;
  logic [15:0] wut_reload = 16'h0002;
  logic [2:0] tamp_pin = 3'h0, tamp_en = 3'h0;
  logic [1:0] tamp_flt = 2'h0;
  logic [4:0] bkp_addr = 5'h00;
  logic [31:0] bkp_wdata = 32'h0000_0000;
  logic [6:0] evt_en = 7'h00, evt_clr = 7'h00, last;
  logic [15:0] subsec, ts_subsec, s0;
  rtcb_pkg::rtcb_cal_s cal_now, ts_cal;
  logic [31:0] bkp_rdata;
  logic [6:0] evt_flags;
  logic evt_wakeup;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles_run = 0;
  int n;

  rtcb_rtc i_rtcb_rtc (.clock, .reset, .clk_en,
    .low_speed_external_osc_xtal(src_pin),
    .low_speed_external_osc_ext(src_pin),
    .low_speed_internal_rc(src_pin), .high_speed_external_osc(src_pin),
    .src_sel, .on_battery, .shutdown_mode, .prediv_a, .prediv_s,
    .cal_minus, .shift_req, .shift_add1s, .shift_amt, .ref_en, .ref_60,
    .ref_pin, .fmt12, .cal_load, .cal_wval, .subsec, .cal_now, .alarm_en,
    .alarm_val, .alarm_mask, .wut_en, .wut_res, .wut_reload, .tamp_pin,
    .tamp_en, .tamp_flt, .tamp_ts, .ts_pin, .ts_en, .ts_cal, .ts_subsec,
    .bkp_we, .bkp_addr, .bkp_wdata, .bkp_rdata, .evt_en, .evt_clr,
    .evt_flags, .evt_wakeup);

  // Clock and a shared source clock, high and low for two cycles each.
  always #50 clock = ~clock;
  always @(negedge clock) begin
    if (src_run) begin
      src_cnt <= src_cnt + 2'h1;
    end
  end
  assign src_pin = src_cnt[1];

  // Cuts a hung run short well above the expected length.
  always @(posedge clock) begin
    cycles_run++;
    if (cycles_run == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic cycles(input int k);
    repeat (k) @(negedge clock);
  endtask : cycles

  task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic rtcb_pkg::rtcb_cal_s mk(input logic pm,
      input logic [5:0] h, input logic [6:0] mi, input logic [6:0] s,
      input logic [2:0] wd, input logic [4:0] mo, input logic [5:0] d,
      input logic [7:0] y);
    mk = {pm, h, mi, s, wd, mo, d, y};
  endfunction : mk

  task automatic do_reset();
    reset = 1'b1;
    cycles(2);
    reset = 1'b0;
  endtask : do_reset

  task automatic cal_wr(input rtcb_pkg::rtcb_cal_s c);
    cal_wval = c;
    cal_load = 1'b1;
    cycles(1);
    cal_load = 1'b0;
  endtask : cal_wr

  task automatic shift(input logic [14:0] amt, input logic add);
    shift_amt = amt;
    shift_add1s = add;
    shift_req = 1'b1;
    cycles(1);
    shift_req = 1'b0;
    cycles(1);
  endtask : shift

  // Loads a calendar, steps one second by a shift, compares the result.
  task automatic roll(input logic f, input rtcb_pkg::rtcb_cal_s a,
      input rtcb_pkg::rtcb_cal_s b);
    fmt12 = f;
    cal_wr(a);
    shift(15'h0001, 1'b1);
    chk("cal_now", b, cal_now);
  endtask : roll

  task automatic bkp_wr(input logic [4:0] a, input logic [31:0] d);
    bkp_addr = a;
    bkp_wdata = d;
    bkp_we = 1'b1;
    cycles(1);
    bkp_we = 1'b0;
    cycles(1);
  endtask : bkp_wr

  task automatic bkp_chk(input logic [4:0] a, input logic [31:0] d);
    bkp_addr = a;
    cycles(1);
    chk("bkp_rdata", d, bkp_rdata);
  endtask : bkp_chk

  task automatic clr();
    evt_clr = 7'h7f;
    cycles(1);
    evt_clr = 7'h00;
  endtask : clr

  task automatic tpulse(input int k);
    tamp_pin[1] = 1'b1;
    cycles(k);
    tamp_pin[1] = 1'b0;
    cycles(8);
  endtask : tpulse

  // Runs one source setting and reports whether the subseconds moved.
  task automatic src_chk(input rtcb_pkg::rtcb_src_e s, input logic b,
      input logic sd, input logic moves);
    src_sel = s;
    on_battery = b;
    shutdown_mode = sd;
    cycles(10);
    n = 0;
    s0 = subsec;
    repeat (800) begin
      cycles(1);
      if (subsec !== s0) n++;
      s0 = subsec;
    end
    chk("subsec moving", moves, n > 0);
  endtask : src_chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Main sequence of tests.
  initial begin
    do_reset();
    chk("cal_now", mk(0, 0, 0, 0, 1, 1, 1, 0), cal_now);
    chk("subsec", 16'h00ff, subsec);
    chk("evt_flags", 0, {evt_wakeup, evt_flags});
    bkp_wr(5'h00, 32'hdead_0001);
    bkp_wr(5'h1f, 32'h8000_7ffe);
    bkp_wr(5'h11, 32'h1234_5678);
    bkp_chk(5'h00, 32'hdead_0001);
    bkp_chk(5'h1f, 32'h8000_7ffe);
    bkp_chk(5'h11, 32'h1234_5678);
    $display("test reset and backup done");
    roll(0, mk(0, 6'h23, 7'h59, 7'h59, 3'h7, 5'h02, 6'h28, 8'h23),
      mk(0, 6'h00, 7'h00, 7'h00, 3'h1, 5'h03, 6'h01, 8'h23));
    roll(0, mk(0, 6'h23, 7'h59, 7'h59, 3'h3, 5'h02, 6'h28, 8'h24),
      mk(0, 6'h00, 7'h00, 7'h00, 3'h4, 5'h02, 6'h29, 8'h24));
    roll(0, mk(0, 6'h23, 7'h59, 7'h59, 3'h4, 5'h02, 6'h29, 8'h24),
      mk(0, 6'h00, 7'h00, 7'h00, 3'h5, 5'h03, 6'h01, 8'h24));
    roll(0, mk(0, 6'h23, 7'h59, 7'h59, 3'h2, 5'h04, 6'h30, 8'h24),
      mk(0, 6'h00, 7'h00, 7'h00, 3'h3, 5'h05, 6'h01, 8'h24));
    roll(0, mk(0, 6'h23, 7'h59, 7'h59, 3'h6, 5'h12, 6'h31, 8'h99),
      mk(0, 6'h00, 7'h00, 7'h00, 3'h7, 5'h01, 6'h01, 8'h00));
    roll(1, mk(0, 6'h11, 7'h59, 7'h59, 3'h2, 5'h01, 6'h05, 8'h10),
      mk(1, 6'h12, 7'h00, 7'h00, 3'h2, 5'h01, 6'h05, 8'h10));
    roll(1, mk(1, 6'h11, 7'h59, 7'h59, 3'h2, 5'h01, 6'h05, 8'h10),
      mk(0, 6'h12, 7'h00, 7'h00, 3'h3, 5'h01, 6'h06, 8'h10));
    fmt12 = 1'b0;
    s0 = subsec;
    shift(15'h7fff, 1'b0);
    chk("subsec", s0 + 16'h7fff, subsec);
    shift(15'h0000, 1'b1);
    chk("subsec", s0 + 16'h7fff, subsec);
    chk("cal_now", mk(0, 6'h12, 7'h00, 7'h00, 3'h3, 5'h01, 6'h06, 8'h10),
      cal_now);
    shift(15'h7fff, 1'b0);
    shift(15'h0002, 1'b0);
    chk("subsec", s0, subsec);
    $display("test calendar and shift done");
    v = mk(0, 6'h08, 7'h30, 7'h15, 3'h4, 5'h06, 6'h11, 8'h25);
    cal_wr(v);
    evt_en = 7'h20;
    tamp_en = 3'h2;
    tamp_ts = 1'b1;
    tpulse(3);
    chk("evt_flags", 7'h28, evt_flags);
    chk("ts_cal", v, ts_cal);
    chk("evt_wakeup", 1, evt_wakeup);
    clr();
    tamp_flt = 2'h3;
    tamp_ts = 1'b0;
    tpulse(5);
    chk("evt_flags", 0, evt_flags);
    tpulse(12);
    chk("evt_flags", 7'h20, evt_flags);
    clr();
    ts_en = 1'b1;
    ts_pin = 1'b1;
    cycles(3);
    ts_pin = 1'b0;
    cycles(8);
    chk("evt_flags", 16'h0008, {8'h00, evt_wakeup, evt_flags});
    ts_en = 1'b0;
    clr();
    on_battery = 1'b1;
    cycles(8);
    chk("evt_flags", 7'h08, evt_flags);
    $display("test tamper and timestamp done");
    src_run = 1'b1;
    src_chk(rtcb_pkg::SRC_XTAL, 0, 0, 1);
    src_chk(rtcb_pkg::SRC_OSC, 0, 0, 1);
    src_chk(rtcb_pkg::SRC_RC, 0, 0, 1);
    src_chk(rtcb_pkg::SRC_HSE, 0, 0, 1);
    src_chk(rtcb_pkg::SRC_RC, 1, 0, 0);
    src_chk(rtcb_pkg::SRC_RC, 0, 1, 0);
    src_chk(rtcb_pkg::SRC_XTAL, 1, 1, 1);
    src_chk(rtcb_pkg::SRC_XTAL, 0, 0, 1);
    $display("test clock sources done");
    clr();
    alarm_val[0] = mk(0, 0, 0, 7'h07, 0, 0, 0, 0);
    alarm_val[1] = mk(0, 0, 0, 7'h09, 0, 0, 0, 0);
    alarm_mask = 8'hee;
    alarm_en = 2'h3;
    evt_en = 7'h03;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (evt_flags[i] !== 1'b1 && n < 3000) begin
        cycles(1);
        n++;
      end
      chk("alarm sec", alarm_val[i].sec, cal_now.sec);
      chk("evt_wakeup", 1, evt_wakeup);
      clr();
    end
    $display("test alarms done");
    alarm_en = 2'h0;
    evt_en = 7'h04;
    wut_en = 1'b1;
    // Every fifty-second window must see the wakeup flag raised.
    for (int m = 0; m < 2; m++) begin
      n = 0;
      last = cal_now.sec;
      repeat (400) begin
        cycles(1);
        if (cal_now.sec !== last && evt_flags[2] !== 1'b1) n++;
        last = cal_now.sec;
      end
      chk("wut flag", 1, evt_flags[2]);
      if (m == 0) clr();
    end
    clr();
    n = 0;
    while (evt_flags[2] !== 1'b1 && n < 300) begin
      cycles(1);
      n++;
    end
    clr();
    n = 0;
    last = cal_now.sec;
    while (evt_flags[2] !== 1'b1 && n < 300) begin
      cycles(1);
      if (cal_now.sec !== last) n++;
      last = cal_now.sec;
    end
    chk("wakeup seconds", 3, n);
    chk("evt_wakeup", 1, evt_wakeup);
    $display("test wakeup timer done");
    wut_en = 1'b0;
    src_run = 1'b0;
    ref_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ref_60 = k[0];
      for (int m = 0; m < 3; m++) begin
        n = 0;
        last = cal_now.sec;
        while (cal_now.sec === last && n < 200) begin
          ref_pin = 1'b1;
          cycles(2);
          ref_pin = 1'b0;
          cycles(2);
          n++;
        end
        if (m == 2) chk("ref edges", k ? 60 : 50, n);
      end
    end
    $display("test reference clock done");
    do_reset();
    bkp_chk(5'h00, 32'hdead_0001);
    bkp_chk(5'h1f, 32'h8000_7ffe);
    bkp_chk(5'h11, 32'h1234_5678);
    $display("test backup retention done");
    // A large drop count swallows the first 511 ticks of a fresh window.
    cal_minus = 9'h1ff;
    src_run = 1'b1;
    src_chk(rtcb_pkg::SRC_XTAL, 0, 0, 0);
    cal_minus = 9'h000;
    src_chk(rtcb_pkg::SRC_XTAL, 0, 0, 1);
    $display("test calibration done");
    end_sim();
  end
endmodule : testbench
